// ===== design/lbs_bus_if.v
// Local bus interface engine with snoop, sizing, hold and flush handling
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "lbs_map.vh"
// ----------------------------------------------------------------------------
// Function
// - Drive four active-low lane enables, lane 3 high byte; float in hold
// - Final transfer low means next burst ready ends cycle; float in hold
// - Back-off floats hold pins without grant and restarts current cycle
// - Back-off beats any ready in the same clock
// - Burst ready ignored idle and first clock; data latched when sampled
// - Single and burst ready together: burst ignored, cycle non-burst
// - Request pending driven whenever request exists; float only in test mode
// - Eight-bit size splits into four cycles, sixteen-bit into two
// - Size inputs sampled every clock before ready; ignored in write-back
// - Cacheable output floats write-through; low for cacheable read or write-back
// - Cacheable high blocks caching; active from cycle start to ready; floats off-bus
// - Core ratio select captured at reset; 0 gives 2x/4x, 1 gives 3x
// - Data and parity driven only in second and later clocks of writes
// - Data-or-control output separates data cycles from control cycles
// - Even parity per lane on writes; read parity never affects execution
// - Snoop strobe taken only off-bus or under address float, not after start, strobe, or modified hit
// - Snoop first sampled second clock after float/back-off, first after grant
// - Purge runs two flush acknowledge cycles in write-back, none in write-through
// - Purge low at reset release enters three-state test mode
// - Modified hit two clocks after strobe until last write-back ready
// - Hold grant with bus float, dropped on leaving hold; float in test mode
// - Address float request stops address drive on the third clock, after the two-flop sync
// ----------------------------------------------------------------------------
module lbs_bus_if (
  input  wire        clk,
  input  wire        srst,
  // Core side request
  input  wire        reqValid,
  input  wire        reqWrite,
  input  wire        reqData,
  input  wire        reqCacheable,
  input  wire        reqWriteBack,
  input  wire [31:2] reqAddr,
  input  wire [3:0]  reqLanes,
  input  wire [31:0] reqWdata,
  output reg         reqDone,
  output reg  [31:0] rdData,
  output reg         rdValid,
  output reg         rdCacheFill,
  output reg         snoopHitModified,
  output reg         snoopValid,
  input  wire        snoopIsModified,
  output reg         ratioSel,
  output reg         flushActive,
  // Bus pins
  output reg  [31:2] addrOut,
  output reg         addrOe_n,
  input  wire [31:4] addrIn,
  output reg  [31:0] dataOut,
  output reg         dataOe_n,
  input  wire [31:0] dataIn,
  output reg  [3:0]  laneParityOut,
  input  wire [3:0]  laneParityIn,
  output reg  [3:0]  byteLaneEnables_n,
  output reg         cycleStart_n,
  output reg         finalTransfer_n,
  output reg         internalCacheable_n,
  output reg         cacheableOe_n,
  output reg         dataOrControl,
  output reg         writeRead,
  output reg         ctlOe_n,
  output reg         internalRequestPending,
  output reg         snoopModifiedHit_n,
  output reg         hitOe_n,
  output reg         holdGrant,
  output reg         miscOe_n,
  input  wire        holdRequest,
  input  wire        addressFloatRequest,
  input  wire        busBackoff_n,
  input  wire        ready_n,
  input  wire        burstReady_n,
  input  wire        narrow8Size_n,
  input  wire        narrow16Size_n,
  input  wire        externalCacheable_n,
  input  wire        snoopAddressStrobe_n,
  input  wire        cachePurge_n,
  input  wire        coreRatioSelect,
  input  wire        coherencyPolicySelect
);

// ----------------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------------
  function [3:0] evenPar;
    input [31:0] d;
    begin
      evenPar = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    end
  endfunction

// ----------------------------------------------------------------------------
// Input synchronisers, two flops each
// ----------------------------------------------------------------------------
  localparam NS = 9;
  wire [NS-1:0] rawIn = {holdRequest, addressFloatRequest, busBackoff_n, ready_n,
                         burstReady_n, narrow8Size_n, narrow16Size_n,
                         externalCacheable_n, snoopAddressStrobe_n};
  reg  [NS-1:0] syncA;
  reg  [NS-1:0] syncB;
  reg  [2:0]    purgeA;
  reg  [2:0]    purgeB;
  reg  [31:0]   dataA;
  reg  [31:0]   dataB;
  reg  [27:0]   snAddrA;
  reg  [27:0]   snAddrB;
  always @(posedge clk) begin
    syncA   <= rawIn;
    syncB   <= syncA;
    purgeA  <= {cachePurge_n, coreRatioSelect, coherencyPolicySelect};
    purgeB  <= purgeA;
    dataA   <= dataIn;
    dataB   <= dataA;
    snAddrA <= addrIn;
    snAddrB <= snAddrA;
  end
  wire sHold   = syncB[8];
  wire sAfloat = syncB[7];
  wire sBoff   = ~syncB[6];
  wire sRdy    = ~syncB[5];
  wire sBrdy   = ~syncB[4];
  wire sBs8    = ~syncB[3];
  wire sBs16   = ~syncB[2];
  wire sKen    = ~syncB[1];
  wire sEads   = ~syncB[0];
  wire sPurge  = ~purgeB[2];

// ----------------------------------------------------------------------------
// Reset straps and test mode
// ----------------------------------------------------------------------------
  reg srstD;
  reg testMode;
  reg wbPolicy;
  always @(posedge clk) begin
    srstD <= srst;
    if (srst) begin
      ratioSel <= `LBS_RATIO_LOW;
      wbPolicy <= 1'h0;
    end else if (srstD) begin
      ratioSel <= purgeB[1];
      wbPolicy <= purgeB[0];
    end
    if (srst)
      testMode <= sPurge;
  end

// ----------------------------------------------------------------------------
// Cycle state machine
// ----------------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_T1   = 5'h02;
  localparam [4:0] ST_T2   = 5'h04;
  localparam [4:0] ST_OFF  = 5'h08;
  localparam [4:0] ST_FACK = 5'h10;
  reg [4:0] state;
  reg [1:0] piecesLeft;
  reg [1:0] beat;
  reg       burst;
  reg       curWrite;
  reg       curData;
  reg       curWb;
  reg       curCache;
  reg       pending;
  reg [1:0] ackLeft;
  reg       flushWb;
  reg       inHold;
  reg       inBoff;
  reg [1:0] snoopWait;
  reg       eadsLast;
  reg [1:0] hitDelay;
  reg       hitHeld;
  reg       startLast;
  reg       curAck;
  wire anyReady  = sRdy | sBrdy;
  wire sizeOk    = ~curWb;
  wire [1:0] pieces = !sizeOk ? `LBS_PIECES_32 :
                      sBs8 ? `LBS_PIECES_8 : sBs16 ? `LBS_PIECES_16 : `LBS_PIECES_32;
  wire offBus    = inHold | inBoff;
  wire snoopOpen = (offBus | sAfloat) && snoopWait == 2'h0;
  wire snoopTake = sEads && snoopOpen && !eadsLast && !startLast
                   && snoopModifiedHit_n;
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      piecesLeft <= 2'h0;
      beat <= 2'h0;
      burst <= 1'h0;
      curWrite <= 1'h0;
      curData <= 1'h0;
      curWb <= 1'h0;
      curCache <= 1'h0;
      pending <= 1'h0;
      ackLeft <= 2'h0;
      flushWb <= 1'h0;
      inHold <= 1'h0;
      inBoff <= 1'h0;
      reqDone <= 1'h0;
      rdValid <= 1'h0;
      rdData <= 32'h0;
      rdCacheFill <= 1'h0;
      flushActive <= 1'h0;
      curAck <= 1'h0;
    end else begin
      reqDone <= 1'h0;
      rdValid <= 1'h0;
      if (sPurge && !flushActive) begin
        flushActive <= 1'h1;
        flushWb <= wbPolicy;
        ackLeft <= `LBS_FLUSH_ACKS;
      end
      inBoff <= sBoff;
      case (state)
        ST_IDLE: begin
          if (sBoff) state <= ST_OFF;
          else if (sHold) begin
            inHold <= 1'h1;
            state <= ST_OFF;
          end else if (flushActive && flushWb && ackLeft != 2'h0) begin
            state <= ST_T1;
            curAck <= 1'h1;
            curWrite <= 1'h0;
            curData <= 1'h0;
            curCache <= 1'h0;
            burst <= 1'h0;
          end else if (flushActive) begin
            flushActive <= 1'h0;
          end else if (reqValid && !reqDone) begin
            state <= ST_T1;
            pending <= 1'h1;
            curAck <= 1'h0;
            curWrite <= reqWrite;
            curData <= reqData;
            curWb <= reqWriteBack;
            curCache <= wbPolicy & (reqCacheable & ~reqWrite | reqWriteBack);
            piecesLeft <= 2'h0;
            beat <= 2'h0;
            burst <= reqWriteBack;
          end
        end
        ST_T1: state <= sBoff ? ST_OFF : curAck ? ST_FACK : ST_T2;
        ST_T2: begin
          if (sBoff) state <= ST_OFF;
          else if (anyReady) begin
            if (!curWrite) begin
              rdData <= dataB;
              rdValid <= 1'h1;
              rdCacheFill <= curCache & sKen;
            end
            if (sRdy) burst <= 1'h0;
            if (piecesLeft == 2'h0 && beat == 2'h0) piecesLeft <= pieces;
            if (sBrdy && !sRdy && burst && beat != `LBS_BEATS_FILL) beat <= beat + 2'h1;
            else if (piecesLeft > 2'h1 || (piecesLeft == 2'h0 && pieces != 2'h0)) begin
              piecesLeft <= piecesLeft == 2'h0 ? pieces : piecesLeft - 2'h1;
              state <= ST_T1;
            end else begin
              state <= ST_IDLE;
              reqDone <= 1'h1;
              pending <= 1'h0;
            end
          end
        end
        ST_OFF: begin
          if (!sBoff && !(inHold && sHold)) begin
            inHold <= 1'h0;
            state <= pending ? ST_T1 : ST_IDLE;
            beat <= 2'h0;
          end
        end
        ST_FACK: begin
          if (sBoff) state <= ST_OFF;
          else if (anyReady) begin
            ackLeft <= ackLeft - 2'h1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

// ----------------------------------------------------------------------------
// Snoop and modified hit
// ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      snoopWait <= 2'h0;
      eadsLast <= 1'h0;
      hitDelay <= 2'h0;
      hitHeld <= 1'h0;
      startLast <= 1'h0;
      snoopValid <= 1'h0;
      snoopHitModified <= 1'h0;
    end else begin
      startLast <= (state == ST_T1);
      eadsLast <= snoopTake;
      snoopValid <= snoopTake;
      snoopHitModified <= snoopTake & snoopIsModified & wbPolicy;
      // Window opens late after the trigger so the address has settled
      if (!offBus && !sAfloat) snoopWait <= 2'h3;
      else if (snoopWait == 2'h3)
        snoopWait <= inHold ? `LBS_SNOOP_WAIT_HG - 2'h1 : `LBS_SNOOP_WAIT_AF - 2'h1;
      else if (snoopWait != 2'h0) snoopWait <= snoopWait - 2'h1;
      if (snoopTake && snoopIsModified && wbPolicy) hitDelay <= `LBS_SNOOP_MODIFIED_HIT_N_DELAY - 2'h1;
      else if (hitDelay != 2'h0) hitDelay <= hitDelay - 2'h1;
      if (hitDelay == 2'h1) hitHeld <= 1'h1;
      else if (hitHeld && curWb && state == ST_T2 && sBrdy && beat == `LBS_BEATS_FILL)
        hitHeld <= 1'h0;
    end
  end

// ----------------------------------------------------------------------------
// Pin drive
// ----------------------------------------------------------------------------
  reg [31:0] wdHold;
  always @(posedge clk) begin
    if (srst) begin
      addrOut <= 30'h0;
      addrOe_n <= 1'h1;
      dataOut <= 32'h0;
      dataOe_n <= 1'h1;
      laneParityOut <= 4'h0;
      byteLaneEnables_n <= `LBS_LANES_NONE_N;
      cycleStart_n <= 1'h1;
      finalTransfer_n <= 1'h1;
      internalCacheable_n <= 1'h1;
      cacheableOe_n <= 1'h1;
      dataOrControl <= 1'h0;
      writeRead <= 1'h0;
      ctlOe_n <= 1'h1;
      internalRequestPending <= 1'h0;
      snoopModifiedHit_n <= 1'h1;
      hitOe_n <= 1'h1;
      holdGrant <= 1'h0;
      miscOe_n <= 1'h1;
      wdHold <= 32'h0;
    end else begin
      if (reqValid) wdHold <= reqWdata;
      addrOut <= reqAddr;
      addrOe_n <= testMode | offBus | sAfloat;
      ctlOe_n <= testMode | offBus;
      byteLaneEnables_n <= ~reqLanes;
      cycleStart_n <= ~(state == ST_T1);
      finalTransfer_n <= ~((state == ST_T1 || state == ST_T2 || state == ST_FACK) &&
                          (!burst || beat == `LBS_BEATS_FILL));
      dataOrControl <= curData;
      writeRead <= curWrite;
      dataOut <= wdHold;
      laneParityOut <= evenPar(wdHold);
      dataOe_n <= ~(curWrite && state == ST_T2 && !sBoff) | testMode;
      internalCacheable_n <= ~(curCache && (state == ST_T1 || state == ST_T2));
      cacheableOe_n <= testMode | ~wbPolicy | offBus;
      internalRequestPending <= pending | (reqValid & ~reqDone);
      miscOe_n <= testMode;
      holdGrant <= inHold;
      snoopModifiedHit_n <= ~hitHeld;
      hitOe_n <= testMode | ~wbPolicy;
    end
  end

endmodule // lbs_bus_if

// ===== design/lbs_map.vh
// Constants for the local bus snoop interface
`ifndef LBS_MAP_VH
`define LBS_MAP_VH
// ----------------------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------------------
`define LBS_LANES_ALL      4'hF
`define LBS_LANES_NONE_N  4'hF
`define LBS_BEATS_FILL    2'h3
`define LBS_PIECES_8      2'h3
`define LBS_PIECES_16     2'h1
`define LBS_PIECES_32     2'h0
// ----------------------------------------------------------------------------
// Snoop timing, clocks
// ----------------------------------------------------------------------------
`define LBS_SNOOP_MODIFIED_HIT_N_DELAY    2'h2
`define LBS_SNOOP_WAIT_AF 2'h2
`define LBS_SNOOP_WAIT_HG 2'h1
`define LBS_FLUSH_ACKS    2'h2
// ----------------------------------------------------------------------------
// Core ratio codes
// ----------------------------------------------------------------------------
`define LBS_RATIO_LOW     1'h0
`define LBS_RATIO_HIGH    1'h1
`endif

// ===== dv/lbs_bus_if_sva.sv
// Checker for the local bus snoop interface pins
`timescale 1ns/1ps
module lbs_bus_if_sva (
  input wire        clk,
  input wire        srst,
  input wire        reqValid,
  input wire        snoopValid,
  input wire        snoopIsModified,
  input wire [31:0] dataOut,
  input wire        dataOe_n,
  input wire [3:0]  laneParityOut,
  input wire        cycleStart_n,
  input wire        writeRead,
  input wire        ctlOe_n,
  input wire        addrOe_n,
  input wire        cacheableOe_n,
  input wire        internalRequestPending,
  input wire        miscOe_n,
  input wire        snoopModifiedHit_n,
  input wire        hitOe_n,
  input wire        holdGrant,
  input wire        holdRequest,
  input wire        addressFloatRequest,
  input wire        busBackoff_n,
  input wire        cachePurge_n,
  input wire        coherencyPolicySelect
);
  reg  [1:0] age;
  reg        testMode;
  wire       up = age == 2'h3;
  // Straps and sync pipes need a few edges before pins mean anything
  always @(posedge clk) begin
    if (srst) begin
      age      <= 2'h0;
      testMode <= !cachePurge_n;
    end else if (!up) begin
      age <= age + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence sSnoopMod;
    snoopValid && snoopIsModified && coherencyPolicySelect;
  endsequence
  sequence sBackoffHeld;
    (!busBackoff_n && !holdRequest) [*5];
  endsequence
  AST_HOLD_FLOAT: assert property (holdGrant |-> ctlOe_n && addrOe_n && cacheableOe_n)
    else $error("bus driven during hold");
  AST_BACKOFF: assert property (sBackoffHeld |-> ctlOe_n && addrOe_n && !holdGrant)
    else $error("back-off did not float without grant");
  AST_AFLOAT: assert property (addressFloatRequest [*4] |-> addrOe_n)
    else $error("address driven under float request");
  AST_WRITE_DATA: assert property (!dataOe_n |-> writeRead && cycleStart_n)
    else $error("data driven outside write data clocks");
  AST_PARITY: assert property (!dataOe_n |-> laneParityOut == {^dataOut[31:24],
    ^dataOut[23:16], ^dataOut[15:8], ^dataOut[7:0]})
    else $error("lane parity not even");
  AST_REQ_PENDING: assert property (reqValid && up && !testMode
    |-> ##[0:3] internalRequestPending && !miscOe_n)
    else $error("request pending not shown");
  AST_TEST_FLOAT: assert property (up && testMode |-> miscOe_n && ctlOe_n && addrOe_n)
    else $error("outputs driven in test mode");
  AST_WT_FLOAT: assert property (up && !coherencyPolicySelect |-> hitOe_n && cacheableOe_n)
    else $error("policy outputs driven in write-through");
  AST_MHIT_DRIVE: assert property (up && coherencyPolicySelect && !testMode |-> !hitOe_n)
    else $error("modified hit floats in write-back");
  AST_SNOOP_GAP: assert property (snoopValid |=> !snoopValid)
    else $error("snoop accepted on adjacent clocks");
  AST_MHIT: assert property (sSnoopMod |-> ##[1:2] !snoopModifiedHit_n)
    else $error("modified hit late");
endmodule // lbs_bus_if_sva
bind lbs_bus_if lbs_bus_if_sva lbs_bus_if_sva_i (.*);

// ===== dv/lbs_bus_if_test.sv
// Testbench for the local bus snoop interface
`timescale 1ns/1ps
module lbs_bus_if_test;
  localparam [31:0] RD_WORD = 32'hC3A51E78;
  reg         clk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, reqData = 1'b0;
  reg         reqCacheable = 1'b0, reqWriteBack = 1'b0, snoopIsModified = 1'b0;
  reg  [31:2] reqAddr = 30'h0000048D;
  reg  [3:0]  reqLanes = 4'hF;
  reg  [31:0] reqWdata = 32'h9617E02B;
  reg  [31:4] addrIn = 28'h0000123;
  reg         holdRequest = 1'b0, addressFloatRequest = 1'b0, busBackoff_n = 1'b1;
  reg         narrow8Size_n = 1'b1, narrow16Size_n = 1'b1, externalCacheable_n = 1'b1;
  reg         snoopAddressStrobe_n = 1'b1, cachePurge_n = 1'b1;
  reg         coreRatioSelect = 1'b0, coherencyPolicySelect = 1'b1;
  reg  [1:0]  mode = 2'h0;
  reg  [3:0]  waitCyc = 4'h2;
  reg         dcSeen = 1'b0, cacheSeen = 1'b1;
  wire        reqDone, rdValid, rdCacheFill, snoopHitModified, snoopValid, ratioSel;
  wire        flushActive, addrOe_n, dataOe_n, cycleStart_n, finalTransfer_n;
  wire        internalCacheable_n, cacheableOe_n, dataOrControl, writeRead, ctlOe_n;
  wire        internalRequestPending, snoopModifiedHit_n, hitOe_n, holdGrant, miscOe_n;
  wire        ready_n, burstReady_n;
  wire [31:2] addrOut;
  wire [31:0] rdData, dataOut, dataIn;
  wire [3:0]  laneParityOut, laneParityIn, byteLaneEnables_n;
  integer     checks = 0, numErrors = 0, starts = 0, snoops = 0, base, t;
  lbs_bus_if lbs_bus_if_i (.*);
  lbs_sys_model #(.RD_WORD(RD_WORD)) lbs_sys_model_i (.*);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (!cycleStart_n) begin
      starts    <= starts + 1;
      dcSeen    <= dataOrControl;
      cacheSeen <= internalCacheable_n | cacheableOe_n;
    end
    if (snoopValid) snoops <= snoops + 1;
  end
  task automatic check(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      numErrors = numErrors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic doReset(input bit pol, input bit ratio, input bit purgeN);
    srst <= 1'b1;
    coherencyPolicySelect <= pol;
    coreRatioSelect <= ratio;
    cachePurge_n <= purgeN;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    cachePurge_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(ratioSel, ratio);
    check({ctlOe_n, addrOe_n, dataOe_n}, {!purgeN, !purgeN, 1'b1});
  endtask
  // kind is {write, data, cacheable, write-back}
  task automatic doReq(input [3:0] kind, input [2:0] expN, input bit chkRd);
    integer b, n;
    @(posedge clk);
    b = starts;
    {reqWrite, reqData, reqCacheable, reqWriteBack} <= kind;
    reqValid <= 1'b1;
    n = 0;
    while (reqDone !== 1'b1 && n < 300) begin
      @(negedge clk);
      n = n + 1;
    end
    if (n >= 300) numErrors = numErrors + 1;
    @(posedge clk);
    reqValid <= 1'b0;
    check(starts - b, expN);
    check(finalTransfer_n, 0);
    check(rdValid, !kind[3]);
    check(dcSeen, kind[2]);
    if (kind[1] && coherencyPolicySelect) check(cacheSeen, 0);
    if (chkRd) check(rdData, RD_WORD);
  endtask
  task automatic doFlush(input [2:0] expN);
    base = starts;
    cachePurge_n <= 1'b0;
    @(posedge clk);
    cachePurge_n <= 1'b1;
    for (t = 0; t < 90 && !(t > 6 && flushActive === 1'b0); t++) @(posedge clk);
    if (t >= 90) numErrors = numErrors + 1;
    check(starts - base, expN);
    if (expN != 0) check(dcSeen, 0);
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    numErrors = numErrors + 1;
    final_report;
  end
  initial begin
    doReset(1'b1, 1'b0, 1'b1);
    doReq(4'b0100, 1, 1);
    mode <= 2'h2;
    doReq(4'b0110, 1, 1);
    mode <= 2'h0;
    doReq(4'b0000, 1, 1);
    doReq(4'b1100, 1, 0);
    narrow8Size_n <= 1'b0;
    doReq(4'b0100, 4, 0);
    {narrow8Size_n, narrow16Size_n} <= 2'b10;
    doReq(4'b1100, 2, 0);
    {narrow8Size_n, narrow16Size_n} <= 2'b11;
    waitCyc <= 4'h8;
    fork
      doReq(4'b0100, 2, 1);
      begin
        @(negedge cycleStart_n);
        repeat (6) @(posedge clk);
        busBackoff_n <= 1'b0;
        repeat (6) @(posedge clk);
        check({ctlOe_n, holdGrant}, 2'h2);
        busBackoff_n <= 1'b1;
      end
    join
    waitCyc <= 4'h2;
    addressFloatRequest <= 1'b1;
    repeat (6) @(posedge clk);
    check(addrOe_n, 1);
    addressFloatRequest <= 1'b0;
    holdRequest <= 1'b1;
    snoopIsModified <= 1'b1;
    for (t = 0; t < 50 && holdGrant !== 1'b1; t++) @(posedge clk);
    check(holdGrant, 1);
    base = snoops;
    @(posedge clk);
    snoopAddressStrobe_n <= 1'b0;
    repeat (2) @(posedge clk);
    snoopAddressStrobe_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(snoops - base, 1);
    check(snoopModifiedHit_n, 0);
    holdRequest <= 1'b0;
    snoopIsModified <= 1'b0;
    mode <= 2'h1;
    narrow8Size_n <= 1'b0;
    doReq(4'b1111, 1, 0);
    narrow8Size_n <= 1'b1;
    mode <= 2'h0;
    repeat (4) @(posedge clk);
    check(snoopModifiedHit_n, 1);
    doFlush(2);
    doReset(1'b0, 1'b1, 1'b1);
    doReq(4'b0110, 1, 1);
    doFlush(0);
    doReset(1'b1, 1'b0, 1'b0);
    check({miscOe_n, hitOe_n}, 2'h3);
    final_report;
  end
endmodule // lbs_bus_if_test

// ===== dv/lbs_sys_model.sv
// System side model answering bus cycles with ready and read data
`timescale 1ns/1ps
module lbs_sys_model #(
  parameter [31:0] RD_WORD = 32'h5AC30F96
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        cycleStart_n,
  input  wire        finalTransfer_n,
  input  wire [1:0]  mode,
  input  wire [3:0]  waitCyc,
  output reg         ready_n = 1'b1,
  output reg         burstReady_n = 1'b1,
  output reg  [31:0] dataIn = 32'h0,
  output reg  [3:0]  laneParityIn = 4'h0
);
  reg       busy = 1'b0;
  reg [3:0] cnt = 4'h0;
  reg [1:0] beat = 2'h0;
  // Mode 0 single ready, 1 burst ready, 2 both at once
  // Lane enables are never looked at, all lanes are served
  always @(posedge clk) begin
    ready_n      <= 1'b1;
    burstReady_n <= 1'b1;
    dataIn       <= ~dataIn;
    laneParityIn <= ~laneParityIn;
    if (srst) begin
      busy <= 1'b0;
    end else if (!cycleStart_n) begin
      busy <= 1'b1;
      cnt  <= 4'h0;
      beat <= 2'h0;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt == waitCyc) begin
        ready_n      <= mode == 2'h1;
        burstReady_n <= mode == 2'h0;
        dataIn       <= RD_WORD;
        laneParityIn <= {^RD_WORD[31:24], ^RD_WORD[23:16],
                         ^RD_WORD[15:8], ^RD_WORD[7:0]};
        busy <= mode == 2'h1 && finalTransfer_n && beat != 2'h3;
        cnt  <= 4'h0;
        beat <= beat + 2'h1;
      end
    end
  end
endmodule // lbs_sys_model
